// ---- hdl/iab_ack_top.sv ----
// acknowledge-bit logic of the two-wire bus interface, core side and link instance
//
// What this block does
// - transmit, checking on: acknowledge 1 sets bit
// - transmit, checking on: acknowledge 0 clears bit
// - writing check enable zero clears bit
// - receive: drive stored level in acknowledge slot
// - read gives captured in transmit, programmed otherwise
// - bit write updates returned level in any direction
`timescale 1ns/10ps
`include "iab_consts.svh"
module iab_ack_top
  import iab_pkg::*;
(
  input  wire logic  CLOCK,          // core clock, 125 MHz
  input  wire logic  RST,            // synchronous reset, active high
  input  wire logic  SCL_CLK,        // bus clock, clocks the link logic
  input  wire logic  SDA_IN,         // data line level
  output logic       SDA_OUT,        // data line drive level, always low
  output logic       SDA_OE,         // high while the data line is pulled
  input  wire logic  FRAME_ACTIVE,   // high from start to stop condition
  input  iab_sw_cmd_t SW_CMD,        // software write strobes and data
  output logic       ACK_READ,       // read-back of ack_level_bit
  output logic       ACK_CHECK_EN,   // read-back of ack_check_enable
  output logic       TX_SELECT,      // read-back of transmit_select
  output logic       ACK_EVENT       // pulse: an acknowledge was captured
);

  // =====================================================================
  // declarations
  logic         ack_prog;        // level returned after reception
  logic         ack_cap;         // level loaded from the receiving device
  logic         ack_check_enable;
  iab_dir_t     transmit_select;
  logic         link_reset;
  logic         frame_clear;
  iab_capture_t capture;
  logic         toggle_sync;
  logic         toggle_seen;
  logic         cap_evt;
  logic         cap_take;
  logic         check_clear;
  logic         next_ack_read;
  logic         link_oe;

  // =====================================================================
  // link-domain resets

  // both are flops so the link sees glitch-free asynchronous resets
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      link_reset <= 1'b1;
    end else begin
      link_reset <= 1'b0;
    end
  end

  // the link clock stops between frames, so the frame level ends the byte count
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      frame_clear <= 1'b1;
    end else begin
      frame_clear <= !FRAME_ACTIVE;
    end
  end

  // =====================================================================
  // link logic
  iab_link u_link (
    .scl_clk     (SCL_CLK),
    .link_reset  (link_reset),
    .frame_clear (frame_clear),
    .sda_in      (SDA_IN),
    .ack_level   (ack_prog),
    .tx_select   (transmit_select),
    .capture     (capture),
    .sda_oe      (link_oe)
  );

  // =====================================================================
  // capture event crossing: toggle synchronised, value stable for a whole byte
  iab_sync #(.WIDTH(1)) u_toggle_sync (
    .clk (CLOCK),
    .d   (capture.toggle),
    .q   (toggle_sync)
  );

  // last toggle level acted upon
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      toggle_seen <= 1'b0;
    end else begin
      toggle_seen <= toggle_sync;
    end
  end

  assign cap_evt     = toggle_sync ^ toggle_seen;
  // capture counts only while checking is on and the direction is transmit
  assign cap_take    = cap_evt && ack_check_enable
                       && (transmit_select == IAB_TRANSMIT);
  assign check_clear = SW_CMD.wr_ctrl && !SW_CMD.check_enable;

  // =====================================================================
  // control state written by software
  // strobes are single-cycle pulses; back-to-back writes are taken one per edge

  // check enable and direction
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ack_check_enable <= `IAB_ACK_CHECK_RESET;
      transmit_select  <= iab_dir_t'(`IAB_TX_SELECT_RESET);
    end else if (SW_CMD.wr_ctrl) begin
      ack_check_enable <= SW_CMD.check_enable;
      transmit_select  <= SW_CMD.transmit_select;
    end
  end

  // programmed acknowledge level; an explicit bit write beats the enable clear
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ack_prog <= `IAB_ACK_LEVEL_RESET;
    end else if (SW_CMD.wr_ack) begin
      ack_prog <= SW_CMD.ack_data;
    end else if (check_clear) begin
      ack_prog <= 1'b0;
    end
  end

  // captured acknowledge; a capture in the clearing cycle wins over the clear
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ack_cap <= `IAB_ACK_LEVEL_RESET;
    end else if (cap_take) begin
      ack_cap <= capture.value;
    end else if (check_clear) begin
      ack_cap <= 1'b0;
    end
  end

  // =====================================================================
  // read-back and pin outputs, all registered

  // read source follows the direction
  always_comb begin
    if (transmit_select == IAB_TRANSMIT) begin
      next_ack_read = ack_cap;
    end else begin
      next_ack_read = ack_prog;
    end
  end

  // read-back lags the stored state by one cycle
  // keeps every output on a flop at the cost of latency: software that polls
  // right after a write must allow two core cycles before trusting the value
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ACK_READ     <= `IAB_ACK_LEVEL_RESET;
      ACK_CHECK_EN <= `IAB_ACK_CHECK_RESET;
      TX_SELECT    <= `IAB_TX_SELECT_RESET;
      ACK_EVENT    <= 1'b0;
    end else begin
      ACK_READ     <= next_ack_read;
      ACK_CHECK_EN <= ack_check_enable;
      TX_SELECT    <= transmit_select;
      ACK_EVENT    <= cap_take;
    end
  end

  // open-drain: only a low is ever driven
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      SDA_OUT <= `IAB_SDA_OUT_LEVEL;
    end else begin
      SDA_OUT <= `IAB_SDA_OUT_LEVEL;
    end
  end

  // enable comes straight from the link's falling-edge flop; a core re-time would
  // shift it by up to a core period, which the slot timing cannot absorb
  assign SDA_OE = link_oe;

  // =====================================================================
  // assertions on the core clock

  sequence s_cap_one;
    cap_take && capture.value;
  endsequence

  sequence s_cap_zero;
    cap_take && !capture.value;
  endsequence

  sequence s_cap_then_tx;
    cap_take ##1 (transmit_select == IAB_TRANSMIT) && !SW_CMD.wr_ctrl;
  endsequence

  AST_CAPTURE_ONE_SETS: assert property (
    @(posedge CLOCK) disable iff (RST)
    s_cap_one |=> ack_cap
  ) else $error("captured acknowledge 1 did not set the bit");

  AST_CAPTURE_ZERO_CLEARS: assert property (
    @(posedge CLOCK) disable iff (RST)
    s_cap_zero |=> !ack_cap
  ) else $error("captured acknowledge 0 did not clear the bit");

  AST_CAPTURE_NEEDS_CHECK: assert property (
    @(posedge CLOCK) disable iff (RST)
    (cap_evt && !ack_check_enable && !check_clear) |=> $stable(ack_cap)
  ) else $error("acknowledge captured while checking was off");

  AST_CHECK_OFF_CLEARS: assert property (
    @(posedge CLOCK) disable iff (RST)
    (check_clear && !cap_take && !SW_CMD.wr_ack) |=> (!ack_cap && !ack_prog)
  ) else $error("writing check enable 0 did not clear the bit");

  AST_CHECK_OFF_READ: assert property (
    @(posedge CLOCK) disable iff (RST)
    (check_clear && !cap_take && !SW_CMD.wr_ack) |-> ##2 !ACK_READ
  ) else $error("read-back not zero two cycles after check enable cleared");

  AST_READ_TRANSMIT: assert property (
    @(posedge CLOCK) disable iff (RST)
    (transmit_select == IAB_TRANSMIT) |=> (ACK_READ == $past(ack_cap))
  ) else $error("transmit read-back is not the captured level");

  AST_READ_RECEIVE: assert property (
    @(posedge CLOCK) disable iff (RST)
    (transmit_select == IAB_RECEIVE) |=> (ACK_READ == $past(ack_prog))
  ) else $error("receive read-back is not the programmed level");

  AST_WRITE_ANY_DIR: assert property (
    @(posedge CLOCK) disable iff (RST)
    SW_CMD.wr_ack |=> (ack_prog == $past(SW_CMD.ack_data))
  ) else $error("acknowledge write did not update the returned level");

  AST_WRITE_KEEPS_CAP: assert property (
    @(posedge CLOCK) disable iff (RST)
    (SW_CMD.wr_ack && !cap_take && !check_clear) |=> $stable(ack_cap)
  ) else $error("acknowledge write disturbed the captured level");

  AST_CAPTURE_READ_BACK: assert property (
    @(posedge CLOCK) disable iff (RST)
    s_cap_then_tx |=> (ACK_READ == $past(capture.value, 2))
  ) else $error("captured acknowledge not visible on read-back");

  AST_EVENT_PULSE: assert property (
    @(posedge CLOCK) disable iff (RST)
    cap_take |=> ACK_EVENT ##1 !ACK_EVENT
  ) else $error("capture event pulse wrong length");

  // =====================================================================
  // further checks on the core clock
  //
  // the captured value reaches this domain without a synchroniser of its own:
  // it is written on the ninth rise and stands for the whole next byte, while
  // the toggle that qualifies it needs two core edges, so it has settled first

  sequence s_rx_write;
    SW_CMD.wr_ack && (transmit_select == IAB_RECEIVE) && !SW_CMD.wr_ctrl;
  endsequence

  AST_RECEIVE_NO_CAPTURE: assert property (
    @(posedge CLOCK) disable iff (RST)
    (cap_evt && (transmit_select == IAB_RECEIVE) && !check_clear) |=> $stable(ack_cap)
  ) else $error("acknowledge captured in receive direction");

  AST_EVENT_FROM_TAKE: assert property (
    @(posedge CLOCK) disable iff (RST)
    ACK_EVENT |-> $past(cap_take)
  ) else $error("capture event pulse without a taken acknowledge");

  AST_EVENT_NEEDS_TX: assert property (
    @(posedge CLOCK) disable iff (RST)
    ACK_EVENT |-> ($past(ack_check_enable) && $past(transmit_select) == IAB_TRANSMIT)
  ) else $error("capture event while checking off or receiving");

  AST_CHECK_CLEAR_PROG: assert property (
    @(posedge CLOCK) disable iff (RST)
    (check_clear && !SW_CMD.wr_ack) |=> !ack_prog
  ) else $error("check enable cleared but programmed level kept");

  AST_CHECK_CLEAR_CAP: assert property (
    @(posedge CLOCK) disable iff (RST)
    (check_clear && !cap_take) |=> !ack_cap
  ) else $error("check enable cleared but captured level kept");

  AST_RECEIVE_READ_WRITE: assert property (
    @(posedge CLOCK) disable iff (RST)
    s_rx_write |-> ##2 (ACK_READ == $past(SW_CMD.ack_data, 2))
  ) else $error("written acknowledge level not read back in receive");

  AST_CTRL_READ_BACK: assert property (
    @(posedge CLOCK) disable iff (RST)
    (SW_CMD.wr_ctrl ##1 !SW_CMD.wr_ctrl) |=> (ACK_CHECK_EN == $past(SW_CMD.check_enable, 2))
  ) else $error("check enable read-back does not follow the write");

endmodule // iab_ack_top

// ---- hdl/iab_consts.svh ----
// constants of the acknowledge-bit block: reset values, slot position, bit count reset and step
`ifndef IAB_CONSTS_SVH
`define IAB_CONSTS_SVH

// =====================================================================
// reset values of the control state
`define IAB_ACK_LEVEL_RESET  1'b0
`define IAB_ACK_CHECK_RESET  1'b0
`define IAB_TX_SELECT_RESET  1'b0
`define IAB_SDA_OUT_LEVEL    1'b0

// =====================================================================
// bit framing on the link: eight data bits, then the acknowledge slot
`define IAB_ACK_SLOT         4'h8
`define IAB_CNT_RESET        4'h0
`define IAB_CNT_STEP         4'h1

`endif

// ---- hdl/iab_link.sv ----
// link-side logic on SCL: bit count, acknowledge capture and acknowledge drive
`timescale 1ns/10ps
`include "iab_consts.svh"
module iab_link
  import iab_pkg::*;
(
  input  wire logic   scl_clk,     // bus clock, rising edge samples the data line
  input  wire logic   link_reset,  // asynchronous, from a CLOCK flop holding RST
  input  wire logic   frame_clear, // asynchronous, high while no frame is running
  input  wire logic   sda_in,      // data line level
  input  wire logic   ack_level,   // programmed acknowledge level, CLOCK domain
  input  wire logic   tx_select,   // transmit_select, CLOCK domain
  output iab_capture_t capture,    // captured acknowledge with its toggle
  output logic        sda_oe       // high while the acknowledge slot is pulled low
);

  logic [3:0] bit_cnt;
  logic [1:0] ctl_sync;
  logic       ack_s;
  logic       tx_s;

  // =====================================================================
  // control levels from the core domain
  iab_sync #(.WIDTH(2)) u_ctl_sync (
    .clk (scl_clk),
    .d   ({ack_level, tx_select}),
    .q   (ctl_sync)
  );
  assign ack_s = ctl_sync[1];
  assign tx_s  = ctl_sync[0];

  // rising edges seen in the current byte; the frame's own signal restarts it
  always_ff @(posedge scl_clk or posedge frame_clear) begin
    if (frame_clear) begin
      bit_cnt <= `IAB_CNT_RESET;
    end else if (bit_cnt == `IAB_ACK_SLOT) begin
      bit_cnt <= `IAB_CNT_RESET;
    end else begin
      bit_cnt <= bit_cnt + `IAB_CNT_STEP;
    end
  end

  // capture of the returned acknowledge; toggle survives frame ends so no false event
  always_ff @(posedge scl_clk or posedge link_reset) begin
    if (link_reset) begin
      capture <= '0;
    end else if (bit_cnt == `IAB_ACK_SLOT && tx_s) begin
      capture.value  <= sda_in;
      capture.toggle <= ~capture.toggle;
    end
  end

  // drive changes on the falling edge so the level is set up before the ninth rise
  always_ff @(negedge scl_clk or posedge frame_clear) begin
    if (frame_clear) begin
      sda_oe <= 1'b0;
    end else begin
      sda_oe <= (bit_cnt == `IAB_ACK_SLOT) && !tx_s && !ack_s;
    end
  end

  // =====================================================================
  // assertions on the link clock
  AST_ACK_DRIVEN_LOW: assert property (
    @(posedge scl_clk) disable iff (frame_clear)
    (bit_cnt == `IAB_ACK_SLOT && !tx_s && !ack_s && $stable(ack_s) && $stable(tx_s)) |-> sda_oe
  ) else $error("receive acknowledge slot not driven to the programmed low level");

  // a programmed high, or the transmit direction, leaves the slot to the pull-up
  AST_ACK_LEFT_HIGH: assert property (
    @(posedge scl_clk) disable iff (frame_clear)
    (bit_cnt == `IAB_ACK_SLOT && (tx_s || ack_s)) |-> !sda_oe
  ) else $error("acknowledge slot pulled low although a high level was due");

  AST_ACK_RELEASED: assert property (
    @(posedge scl_clk) disable iff (frame_clear)
    (bit_cnt == `IAB_CNT_STEP) |-> !sda_oe
  ) else $error("data line still driven after the acknowledge slot");

endmodule // iab_link

// ---- hdl/iab_pkg.sv ----
// types shared by the acknowledge-bit block
package iab_pkg;

  // =====================================================================
  // direction of the current transfer
  typedef enum logic {
    IAB_RECEIVE  = 1'b0,
    IAB_TRANSMIT = 1'b1
  } iab_dir_t;

  // =====================================================================
  // software command strobes and their data, all on CLOCK
  typedef struct packed {
    logic     wr_ack;            // write strobe of the acknowledge level
    logic     ack_data;          // value written to the acknowledge level
    logic     wr_ctrl;           // write strobe of check enable and direction
    logic     check_enable;      // value written to ack_check_enable
    iab_dir_t transmit_select;   // value written to transmit_select
  } iab_sw_cmd_t;

  // =====================================================================
  // capture result handed from the link domain, qualified by the toggle
  typedef struct packed {
    logic toggle;                // flips once per captured acknowledge
    logic value;                 // level seen in the acknowledge slot
  } iab_capture_t;

endpackage

// ---- hdl/iab_sync.sv ----
// two-flop level synchroniser
`timescale 1ns/10ps
module iab_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,   // destination clock
  input  wire logic [WIDTH-1:0] d,     // level from the other domain
  output logic      [WIDTH-1:0] q      // synchronised level
);

  logic [WIDTH-1:0] stage1;

  // no reset: the chain settles within two edges, and a reset here would fake a level
  always_ff @(posedge clk) begin
    stage1 <= d;
    q      <= stage1;
  end

endmodule // iab_sync

// ---- tb/iab_bus_partner.sv ----
// behavioural model of the far bus device: clocks the link and answers in the acknowledge slot
`timescale 1ns/10ps
module iab_bus_partner (
  output logic      scl,        // bus clock, stands high between frames
  output logic      sda_low,    // high while this device pulls the data line low
  output logic      slot_level, // data line level seen in the last acknowledge slot
  input  wire logic sda_wire    // resolved data line level
);

  // =====================================================================
  // idle: both lines released, the pull-up holds them high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    slot_level = 1'b0;
  end

  // =====================================================================
  // one byte: eight data bits msb first, then the slot; 64 ns bit period
  task automatic send_byte(input logic [7:0] data, input logic ack_bit, input logic drive_ack);
    #5;
    for (int i = 7; i >= 0; i--) begin
      scl = 1'b0;
      #16 sda_low = !data[i];
      #16 scl = 1'b1;
      #32;
    end
    scl = 1'b0;
    // in receive direction the line is left to the block under test
    #16 sda_low = drive_ack ? !ack_bit : 1'b0;
    #16 scl = 1'b1;
    #16 slot_level = sda_wire;
    #16 scl = 1'b0;
    // hold time over: release so the pull-up shows, not the old bit
    #16 sda_low = 1'b0;
    #16;
  endtask

  // =====================================================================
  // back to idle once the frame has ended; scl stays low until then
  task automatic to_idle();
    scl = 1'b1;
    sda_low = 1'b0;
  endtask

endmodule // iab_bus_partner

// ---- tb/tb_i2c_acknowledge_bit_logic.sv ----
// self-checking bench of the acknowledge-bit block with a far-side bus model
`timescale 1ns/10ps
module tb_i2c_acknowledge_bit_logic
  import iab_pkg::*;
;
  logic        clock;
  logic        rst;
  logic        frame_active;
  logic        sda_out;
  logic        sda_oe;
  logic        ack_read;
  logic        ack_check_en;
  logic        tx_select;
  logic        ack_event;
  logic        sda_wire;
  logic        scl;
  logic        sda_low;
  logic        slot_level;
  iab_sw_cmd_t sw_cmd;
  int          compares = 0;
  int          miscompares = 0;
  int          cycles = 0;
  int          events = 0;

  // =====================================================================
  // clock, wired-and data line with pull-up
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  assign sda_wire = (sda_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;

  iab_ack_top DUT (
    .CLOCK        (clock),
    .RST          (rst),
    .SCL_CLK      (scl),
    .SDA_IN       (sda_wire),
    .SDA_OUT      (sda_out),
    .SDA_OE       (sda_oe),
    .FRAME_ACTIVE (frame_active),
    .SW_CMD       (sw_cmd),
    .ACK_READ     (ack_read),
    .ACK_CHECK_EN (ack_check_en),
    .TX_SELECT    (tx_select),
    .ACK_EVENT    (ack_event)
  );

  iab_bus_partner partner (
    .scl        (scl),
    .sda_low    (sda_low),
    .slot_level (slot_level),
    .sda_wire   (sda_wire)
  );

  // =====================================================================
  // capture pulses are short, so they are counted as they happen
  always @(posedge clock) begin
    if (ack_event === 1'b1) events++;
  end

  // a hang costs a mismatch; a full run takes well under 2000 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end

  // =====================================================================
  // shared tasks
  task automatic final_report();
    if (miscompares == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // read-back source by direction: captured when transmitting, programmed otherwise
  function automatic logic exp_read(input iab_dir_t dir, input logic captured,
                                    input logic programmed);
    return (dir == IAB_TRANSMIT) ? captured : programmed;
  endfunction

  // read-back settles two edges after the command edge
  task automatic write_ack(input logic v);
    @(posedge clock);
    sw_cmd.wr_ack <= 1'b1;
    sw_cmd.ack_data <= v;
    @(posedge clock);
    sw_cmd.wr_ack <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic write_ctrl(input logic ce, input iab_dir_t dir);
    @(posedge clock);
    sw_cmd.wr_ctrl <= 1'b1;
    sw_cmd.check_enable <= ce;
    sw_cmd.transmit_select <= dir;
    @(posedge clock);
    sw_cmd.wr_ctrl <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check(ack_check_en, ce);
    check(tx_select, dir);
  endtask

  // the capture pulse lands 3-4 cycles after the slot, well inside this wait
  task automatic run_frame(input logic tx, input logic ack_bit);
    @(posedge clock);
    frame_active <= 1'b1;
    repeat (3) @(posedge clock);
    partner.send_byte(8'($urandom), ack_bit, tx);
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic end_frame();
    @(posedge clock);
    frame_active <= 1'b0;
    repeat (3) @(posedge clock);
    partner.to_idle();
    repeat (4) @(posedge clock);
  endtask

  // =====================================================================
  // main sequence
  initial begin
    logic b;
    int   e0;
    void'($urandom(53));
    rst = 1'b1;
    frame_active = 1'b0;
    sw_cmd = '0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check(ack_read, 1'b0);
    check(sda_oe, 1'b0);
    check(sda_out, 1'b0);
    // receive: programmed level read back and driven in the slot
    write_ctrl(1'b0, IAB_RECEIVE);
    for (int i = 0; i < 4; i++) begin
      b = (i < 2) ? i[0] : 1'($urandom);
      write_ack(b);
      check(ack_read, exp_read(IAB_RECEIVE, 1'b0, b));
      run_frame(1'b0, 1'b0);
      check(slot_level, b);
      end_frame();
    end
    // transmit, checking on: programmed opposite so a wrong source shows
    for (int i = 0; i < 6; i++) begin
      b = (i < 2) ? !i[0] : 1'($urandom);
      write_ctrl(1'b1, IAB_TRANSMIT);
      write_ack(!b);
      e0 = events;
      run_frame(1'b1, b);
      check(ack_read, exp_read(IAB_TRANSMIT, b, !b));
      check(1'(events - e0 == 1), 1'b1);
      write_ctrl(1'b0, IAB_TRANSMIT);
      check(ack_read, 1'b0);
      end_frame();
    end
    // transmit, checking off: a returned 1 must be ignored
    e0 = events;
    run_frame(1'b1, 1'b1);
    check(1'(events == e0), 1'b1);
    check(ack_read, 1'b0);
    end_frame();
    // level written while transmitting serves the next reception
    write_ctrl(1'b1, IAB_TRANSMIT);
    write_ack(1'b1);
    check(ack_read, exp_read(IAB_TRANSMIT, 1'b0, 1'b1));
    // a bit-manipulation write copies the read-back into the level, so set it again
    write_ack(ack_read);
    write_ack(1'b1);
    write_ctrl(1'b1, IAB_RECEIVE);
    check(ack_read, 1'b1);
    run_frame(1'b0, 1'b0);
    check(slot_level, 1'b1);
    end_frame();
    write_ctrl(1'b0, IAB_RECEIVE);
    check(ack_read, 1'b0);
    final_report();
  end

endmodule // tb_i2c_acknowledge_bit_logic
